/* verilog/pcfg_control.v */
// Purpose: configuration bits 13..6 (and swap bit 14) of the phy_control
// Assumes: management write strobe and write data from an mii management engine on clock
// Notes: straps and the signal detect pin are synchronised; other bits of the register live elsewhere
//
// Overview of operation
// RQ1 - manual polarity uses swap field for polarity
// RQ2 - manual polarity resets 0; auto detection otherwise
// RQ3 - heartbeat enable resets 1; test after frames
// RQ4 - collision pulse 600-1600 ns later, 500-1500 wide
// RQ5 - factory test field resets 0, reserved mode
// RQ6 - optical mode disables scrambler and descrambler
// RQ7 - optical mode powers down twisted pair, enables optical
// RQ8 - optical strap low forces optical bit one
// RQ9 - far fault sends 84 ones and zero
// RQ10 - fault pattern start sets status flag
// RQ11 - code bypass maps nibble plus error bits
// RQ12 - code bypass resets 0; strap forces one
// RQ13 - align bypass feeds symbols straight to decoder
// RQ14 - duplex led shows duplex only when set
// RQ15 - swap field inverts receive pair polarity
// RQ16 - align bypass resets 0
`timescale 1ns/1ns
`include "pcfg_consts.vh"

module pcfg_control #(
	parameter HB_DELAY = `PCFG_HB_DELAY_CYC,
	parameter HB_WIDTH = `PCFG_HB_WIDTH_CYC
) (
	input wire clock, // core clock
	input wire reset_n, // async reset, active low
	input wire reg_write, // one-cycle write strobe
	input wire [4:0] reg_addr, // management register address
	input wire [15:0] reg_wdata, // write data
	output reg [15:0] ctl_rdata, // control bits 14..6, others zero
	input wire sts_read, // status register read pulse
	output wire fault_flag_rd, // far fault flag for status bit
	input wire optical_strap_n, // strap pin, low forces optical
	input wire code_bypass_strap_n, // strap pin, low forces code bypass
	input wire is_10base_t, // 10 mbit mode selected
	input wire tx_frame_end, // pulse at last positive edge of frame
	input wire link_collision, // real collision detect
	input wire full_duplex, // operating duplex
	input wire auto_polarity_inverted, // detected link pulse inversion
	input wire signal_detect, // optical signal detect pin
	input wire [3:0] tx_nibble, // transmit nibble
	input wire tx_error_in, // transmit error, msb of 5b code
	input wire [4:0] rx_code, // received 5b group
	output reg [3:0] rx_nibble, // receive nibble in code bypass
	output reg rx_error_out, // receive error msb in code bypass
	output reg [4:0] tx_code, // 5b code to transmitter
	output reg rx_invert, // invert 10base-t receive pair
	output reg collision_out, // collision output
	output reg duplex_collision_led, // combined led driver
	output reg scrambler_off, // scrambler and descrambler bypass
	output reg pair_powerdown, // twisted pair low-power state
	output reg optical_enable, // optical terminals active
	output reg fault_tx_active, // far fault pattern in progress
	output reg fault_tx_bit, // fault pattern bit stream
	output reg code_bypass, // encoder and decoder bypassed
	output reg align_bypass_out, // aligner bypassed
	output reg factory_mode // manufacturing test mode
);
	// ==========================================================
	// synchronisers
	// every pin resets high: straps read as not forced, signal as present,
	// so no fault pattern and no forced mode can flash out of reset
	localparam N_SYNC = 3;
	wire [N_SYNC-1:0] sync_in;
	wire [N_SYNC-1:0] sync_out;
	assign sync_in = {signal_detect, code_bypass_strap_n, optical_strap_n};
	genvar g;
	generate
		for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
			reg [1:0] stage;
			always @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					stage <= 2'h3;
				end else begin
					stage <= {stage[0], sync_in[g]};
				end
			end
			// only the second stage is read by the logic below
			assign sync_out[g] = stage[1];
		end
	endgenerate
	wire opt_forced = ~sync_out[0];
	wire cb_forced = ~sync_out[1];
	wire sd_ok = sync_out[2];

	// ==========================================================
	// register fields
	reg manual_polarity_select;
	reg polarity_swap;
	reg heartbeat_test_enable;
	reg factory_test_select;
	reg optical_bit;
	reg far_fault_send_enable;
	reg code_bypass_bit;
	reg align_bypass;
	reg duplex_led_only;
	wire wr = reg_write && (reg_addr == `PCFG_CTL_ADDR);
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			manual_polarity_select <= `PCFG_RST_MANUAL; // [RQ2]
			polarity_swap <= `PCFG_RST_SWAP;
			heartbeat_test_enable <= `PCFG_RST_HEARTBEAT; // [RQ3]
			factory_test_select <= `PCFG_RST_FACTORY; // [RQ5]
			optical_bit <= `PCFG_RST_OPTICAL; // [RQ6]
			far_fault_send_enable <= `PCFG_RST_FAULT_EN; // [RQ9]
			code_bypass_bit <= `PCFG_RST_CODE_BYP; // [RQ12]
			align_bypass <= `PCFG_RST_ALIGN_BYP; // [RQ16]
			duplex_led_only <= `PCFG_RST_DUPLEX_LED; // [RQ14]
		end else if (wr) begin
			manual_polarity_select <= reg_wdata[`PCFG_BIT_MANUAL];
			polarity_swap <= reg_wdata[`PCFG_BIT_SWAP];
			heartbeat_test_enable <= reg_wdata[`PCFG_BIT_HEARTBEAT];
			factory_test_select <= reg_wdata[`PCFG_BIT_FACTORY];
			optical_bit <= reg_wdata[`PCFG_BIT_OPTICAL];
			far_fault_send_enable <= reg_wdata[`PCFG_BIT_FAULT_EN];
			code_bypass_bit <= reg_wdata[`PCFG_BIT_CODE_BYP];
			align_bypass <= reg_wdata[`PCFG_BIT_ALIGN_BYP];
			duplex_led_only <= reg_wdata[`PCFG_BIT_DUPLEX_LED];
		end
	end
	// strap overrides the stored bit; a written 0 is kept but masked
	wire optical_mode = optical_bit | opt_forced; // [RQ8]
	wire code_byp_eff = code_bypass_bit | cb_forced; // [RQ12]

	always @* begin
		ctl_rdata = 16'h0000;
		ctl_rdata[`PCFG_BIT_SWAP] = polarity_swap;
		ctl_rdata[`PCFG_BIT_MANUAL] = manual_polarity_select;
		ctl_rdata[`PCFG_BIT_HEARTBEAT] = heartbeat_test_enable;
		ctl_rdata[`PCFG_BIT_FACTORY] = factory_test_select;
		ctl_rdata[`PCFG_BIT_OPTICAL] = optical_mode; // [RQ8]
		ctl_rdata[`PCFG_BIT_FAULT_EN] = far_fault_send_enable;
		ctl_rdata[`PCFG_BIT_CODE_BYP] = code_byp_eff; // [RQ12]
		ctl_rdata[`PCFG_BIT_ALIGN_BYP] = align_bypass;
		ctl_rdata[`PCFG_BIT_DUPLEX_LED] = duplex_led_only;
	end

	// ==========================================================
	// heartbeat state machine
	localparam HB_IDLE = 3'h1;
	localparam HB_WAIT = 3'h2;
	localparam HB_PULSE = 3'h4;
	reg [2:0] hb_state;
	reg [7:0] hb_count;
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hb_state <= HB_IDLE;
			hb_count <= 8'h00;
		end else begin
			case (hb_state)
				HB_IDLE: begin
					if (tx_frame_end && heartbeat_test_enable && is_10base_t) begin // [RQ3]
						hb_state <= HB_WAIT;
						hb_count <= HB_DELAY[7:0] - 8'h01;
					end
				end
				HB_WAIT: begin
					if (hb_count == 8'h00) begin // [RQ4]
						hb_state <= HB_PULSE;
						hb_count <= HB_WIDTH[7:0] - 8'h01;
					end else begin
						hb_count <= hb_count - 8'h01;
					end
				end
				HB_PULSE: begin
					if (hb_count == 8'h00) begin // [RQ4]
						hb_state <= HB_IDLE;
					end else begin
						hb_count <= hb_count - 8'h01;
					end
				end
				default: begin
					hb_state <= HB_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// far fault pattern: 84 ones then a zero, repeated
	reg [6:0] ff_count;
	reg far_fault_flag;
	wire ff_need = far_fault_send_enable && optical_mode && !sd_ok; // [RQ9]
	wire ff_start = ff_need && !fault_tx_active;
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ff_count <= 7'h00;
			fault_tx_active <= 1'b0;
			fault_tx_bit <= 1'b0;
			far_fault_flag <= 1'b0;
		end else begin
			fault_tx_active <= ff_need;
			if (!ff_need || ff_count == `PCFG_FAULT_ONES) begin
				ff_count <= 7'h00;
			end else begin
				ff_count <= ff_count + 7'h01;
			end
			fault_tx_bit <= ff_need && (ff_count != `PCFG_FAULT_ONES); // [RQ9]
			// set wins over read-clear
			if (ff_start) begin
				far_fault_flag <= 1'b1; // [RQ10]
			end else if (sts_read && reg_addr == `PCFG_STS_ADDR) begin
				far_fault_flag <= 1'b0;
			end
		end
	end
	assign fault_flag_rd = far_fault_flag;

	// ==========================================================
	// mode outputs
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_invert <= 1'b0;
			collision_out <= 1'b0;
			duplex_collision_led <= 1'b0;
			scrambler_off <= 1'b0;
			pair_powerdown <= 1'b0;
			optical_enable <= 1'b0;
			code_bypass <= 1'b0;
			align_bypass_out <= 1'b0;
			factory_mode <= 1'b0;
			tx_code <= 5'h00;
			rx_nibble <= 4'h0;
			rx_error_out <= 1'b0;
		end else begin
			// polarity: manual swap or detected inversion
			rx_invert <= manual_polarity_select ? polarity_swap : auto_polarity_inverted; // [RQ1] [RQ2] [RQ15]
			collision_out <= link_collision || (hb_state == HB_PULSE); // [RQ4]
			duplex_collision_led <= duplex_led_only ? full_duplex
				: (full_duplex || link_collision); // [RQ14]
			scrambler_off <= optical_mode; // [RQ6]
			pair_powerdown <= optical_mode; // [RQ7]
			optical_enable <= optical_mode; // [RQ7]
			code_bypass <= code_byp_eff; // [RQ11]
			align_bypass_out <= align_bypass; // [RQ13]
			factory_mode <= factory_test_select; // [RQ5]
			tx_code <= {tx_error_in, tx_nibble}; // [RQ11]
			rx_nibble <= rx_code[3:0]; // [RQ11]
			rx_error_out <= rx_code[4]; // [RQ11]
		end
	end
endmodule // pcfg_control

/* verilog/pcfg_consts.vh */
// Purpose: constants for the phy control configuration bits block
// Assumes: 16-bit management register, 100 MHz core clock
// Notes: definitions only
`ifndef PCFG_CONSTS_VH
`define PCFG_CONSTS_VH
// ==========================================================
// register and field positions
`define PCFG_CTL_ADDR 5'h11
`define PCFG_STS_ADDR 5'h12
`define PCFG_BIT_SWAP 14
`define PCFG_BIT_MANUAL 13
`define PCFG_BIT_HEARTBEAT 12
`define PCFG_BIT_FACTORY 11
`define PCFG_BIT_OPTICAL 10
`define PCFG_BIT_FAULT_EN 9
`define PCFG_BIT_CODE_BYP 8
`define PCFG_BIT_ALIGN_BYP 7
`define PCFG_BIT_DUPLEX_LED 6
`define PCFG_BIT_FAULT_FLAG 10
// ==========================================================
// reset values
`define PCFG_RST_MANUAL 1'h0
`define PCFG_RST_SWAP 1'h0
`define PCFG_RST_HEARTBEAT 1'h1
`define PCFG_RST_FACTORY 1'h0
`define PCFG_RST_OPTICAL 1'h0
`define PCFG_RST_FAULT_EN 1'h0
`define PCFG_RST_CODE_BYP 1'h0
`define PCFG_RST_ALIGN_BYP 1'h0
`define PCFG_RST_DUPLEX_LED 1'h0
// ==========================================================
// timing
`define PCFG_CLK_NS 10
`define PCFG_HB_DELAY_MIN_NS 600
`define PCFG_HB_DELAY_MAX_NS 1600
`define PCFG_HB_WIDTH_MIN_NS 500
`define PCFG_HB_WIDTH_MAX_NS 1500
// delay: least time rounded up, plus 40 cycles of margin
`define PCFG_HB_DELAY_CYC ((`PCFG_HB_DELAY_MIN_NS + `PCFG_CLK_NS - 1) / `PCFG_CLK_NS + 40)
`define PCFG_HB_WIDTH_CYC ((`PCFG_HB_WIDTH_MIN_NS + `PCFG_CLK_NS - 1) / `PCFG_CLK_NS + 40)
`define PCFG_FAULT_ONES 84
`endif

/* verif/pcfg_control_properties.sv */
// Purpose: temporal checks on the pcfg_control ports
// Assumes: one clock, reset_n async active low
// Notes: bound from the bench top file
`timescale 1ns/1ns
module pcfg_control_properties (
	input wire clock, // core clock
	input wire reset_n, // reset
	input wire [15:0] ctl_rdata, // read image
	input wire fault_flag_rd, // fault flag
	input wire optical_strap_n, // strap
	input wire code_bypass_strap_n, // strap
	input wire is_10base_t, // mode
	input wire tx_frame_end, // frame end
	input wire link_collision, // collision in
	input wire full_duplex, // duplex in
	input wire auto_polarity_inverted, // auto polarity
	input wire signal_detect, // optical detect
	input wire rx_invert, // polarity out
	input wire collision_out, // collision out
	input wire duplex_collision_led, // led
	input wire scrambler_off, // optical
	input wire pair_powerdown, // optical
	input wire optical_enable, // optical
	input wire fault_tx_active, // fault running
	input wire fault_tx_bit, // fault stream
	input wire code_bypass, // bypass out
	input wire align_bypass_out, // bypass out
	input wire factory_mode // test mode
);
	reg [7:0] hi_cnt;
	reg [7:0] ones;
	reg lc_d;
	// collision_out lags link_collision by one edge; lc_d lines them up so
	// that cycles carried by a real collision are never counted as heartbeat
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hi_cnt <= 8'h00;
			ones <= 8'h00;
			lc_d <= 1'b0;
		end else begin
			lc_d <= link_collision;
			hi_cnt <= (collision_out && !lc_d) ? hi_cnt + 8'h01 : 8'h00;
			ones <= fault_tx_bit ? ones + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ====
	// registered outputs follow the effective fields one edge later
	a_polarity_source: assert property ($past(reset_n) |->
		rx_invert == $past(ctl_rdata[13] ? ctl_rdata[14] : auto_polarity_inverted))
		else $error("receive polarity source wrong");
	a_mode_outputs: assert property ($past(reset_n) |->
		{scrambler_off, pair_powerdown, optical_enable, code_bypass, align_bypass_out, factory_mode}
		== $past({{3{ctl_rdata[10]}}, ctl_rdata[8:7], ctl_rdata[11]})) else $error("mode outputs wrong");
	a_led_source: assert property ($past(reset_n) |-> duplex_collision_led ==
		$past(ctl_rdata[6] ? full_duplex : full_duplex | link_collision)) else $error("led wrong");
	a_optical_strap: assert property ((!optical_strap_n)[*3] |-> ctl_rdata[10])
		else $error("optical strap not forcing");
	a_codebyp_strap: assert property ((!code_bypass_strap_n)[*3] |-> ctl_rdata[8])
		else $error("code bypass strap not forcing");
	// 60..160 cycles is 600..1600 ns at 10 ns
	a_heartbeat_delay: assert property (tx_frame_end && is_10base_t && ctl_rdata[12] &&
		!collision_out && !link_collision |-> ##[60:160] $rose(collision_out))
		else $error("heartbeat delay out of range");
	// short runs are real collisions, so only long pulses are judged
	a_heartbeat_width: assert property ($fell(collision_out) && hi_cnt > 8'h08 |->
		hi_cnt >= 8'h32 && hi_cnt <= 8'h96) else $error("heartbeat width out of range");
	a_fault_send: assert property (
		(ctl_rdata[9] && ctl_rdata[10] && !signal_detect)[*5] |-> fault_tx_active)
		else $error("fault pattern not sent");
	a_fault_flag: assert property ($rose(fault_tx_active) |-> fault_flag_rd)
		else $error("fault flag not set");
	a_fault_pattern: assert property ($fell(fault_tx_bit) && fault_tx_active |->
		ones == 8'h54 ##1 (fault_tx_bit || !fault_tx_active)) else $error("fault pattern wrong");
	c_heartbeat: cover property ($rose(collision_out) && !link_collision);
	c_fault: cover property ($fell(fault_tx_bit) && fault_tx_active);
	c_strap: cover property (!optical_strap_n && ctl_rdata[10]);
endmodule // pcfg_control_properties

/* verif/pcfg_mgmt_model.sv */
// Purpose: management station driving the control register
// Assumes: strobes launched 1 ns after the rising edge
// Notes: released data bus shows inverted value, never the stale one
`timescale 1ns/1ns
module pcfg_mgmt_model (
	input wire clock, // core clock
	output reg reg_write = 1'b0, // write strobe
	output reg [4:0] reg_addr = 5'h00, // address
	output reg [15:0] reg_wdata = 16'h0000, // write data
	output reg sts_read = 1'b0 // status read
);
	task access(input [4:0] addr, input [15:0] data, input is_read);
		begin
			@(posedge clock);
			#1;
			reg_addr = addr;
			reg_wdata = data & 16'hF7FF; // factory field kept clear
			reg_write = !is_read;
			sts_read = is_read;
			@(posedge clock);
			#1;
			reg_write = 1'b0;
			sts_read = 1'b0;
			reg_wdata = ~reg_wdata;
		end
	endtask
endmodule // pcfg_mgmt_model

/* verif/pcfg_control_tb.sv */
// Purpose: self-checking bench for pcfg_control
// Assumes: 100 MHz clock, default heartbeat parameters
// Notes: random fields from an lfsr seeded 32'h8EF7
`timescale 1ns/1ns
module pcfg_control_tb;
	reg clock, reset_n = 1'b0, optical_strap_n = 1'b1, code_bypass_strap_n = 1'b1;
	reg is_10base_t = 1'b1, tx_frame_end = 1'b0, link_collision = 1'b0, full_duplex = 1'b0;
	reg auto_polarity_inverted = 1'b0, signal_detect = 1'b1, tx_error_in = 1'b0;
	reg [3:0] tx_nibble = 4'h0;
	reg [4:0] rx_code = 5'h00;
	wire reg_write, sts_read, fault_flag_rd, rx_error_out, rx_invert, collision_out, factory_mode;
	wire duplex_collision_led, scrambler_off, pair_powerdown, optical_enable, fault_tx_active;
	wire fault_tx_bit, code_bypass, align_bypass_out;
	wire [4:0] reg_addr, tx_code;
	wire [15:0] reg_wdata, ctl_rdata;
	wire [3:0] rx_nibble;
	integer n_fail = 0, check_count = 0, cyc = 0, n, i, k;
	reg [31:0] seed = 32'h8EF7;
	reg [15:0] stored = 16'h1000;
	pcfg_control u_dut (.*);
	pcfg_mgmt_model u_mgmt (.*);
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [15:0] exp_ctl(input [15:0] w, input opt_n, input cb_n);
		exp_ctl = (w & 16'h7FC0) | (opt_n ? 16'h0000 : 16'h0400) | (cb_n ? 16'h0000 : 16'h0100);
	endfunction
	task step(input integer c);
		repeat (c) @(posedge clock) #1;
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [15:0] d);
		begin
			u_mgmt.access(5'h11, d, 1'b0);
			stored = d & 16'hF7FF;
			step(2);
		end
	endtask
	// frame end, then measure delay and width of the collision pulse
	task hb(input on);
		begin
			tx_frame_end = 1'b1;
			step(1);
			tx_frame_end = 1'b0;
			for (n = 1; !collision_out && n < 200; n = n + 1) step(1);
			for (k = 0; collision_out && k < 200; k = k + 1) step(1);
			chk(16'(n >= 60 && n <= 160 && k >= 50 && k <= 150), 16'(on));
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// ====
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// whole run needs about 1000 cycles
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			conclude;
		end
	end
	initial begin
		step(20);
		reset_n = 1'b1;
		step(3);
		chk(ctl_rdata, 16'h1000);
		$display("test reset done");
		for (i = 0; i < 24; i = i + 1) begin
			seed = lfsr(seed);
			{auto_polarity_inverted, full_duplex, link_collision} = seed[18:16];
			{tx_error_in, tx_nibble, rx_code} = seed[28:19];
			wr(seed[15:0]);
			chk(ctl_rdata, exp_ctl(stored, 1'b1, 1'b1));
			chk(16'(rx_invert), 16'(stored[13] ? stored[14] : auto_polarity_inverted));
			chk(16'(duplex_collision_led), 16'(stored[6] ? full_duplex : full_duplex | link_collision));
			chk(16'({scrambler_off, pair_powerdown, optical_enable, align_bypass_out, factory_mode}),
				16'({{3{stored[10]}}, stored[7], 1'b0}));
			chk(16'(code_bypass), 16'(stored[8]));
			if (stored[8])
				chk({tx_code, rx_error_out, rx_nibble}, {tx_error_in, tx_nibble, rx_code});
		end
		link_collision = 1'b0;
		u_mgmt.access(5'h12, 16'hFFFF, 1'b0);
		step(2);
		chk(ctl_rdata, exp_ctl(stored, 1'b1, 1'b1));
		$display("test random writes done");
		optical_strap_n = 1'b0;
		code_bypass_strap_n = 1'b0;
		wr(16'h0000);
		chk(ctl_rdata, 16'h0500);
		chk(16'({optical_enable, code_bypass}), 16'h0003);
		optical_strap_n = 1'b1;
		code_bypass_strap_n = 1'b1;
		step(4);
		chk(ctl_rdata, 16'h0000);
		$display("test straps done");
		hb(1'b0);
		wr(16'h1000);
		hb(1'b1);
		is_10base_t = 1'b0;
		hb(1'b0);
		is_10base_t = 1'b1;
		$display("test heartbeat done");
		signal_detect = 1'b0;
		wr(16'h0600);
		for (n = 0; !fault_tx_active && n < 20; n = n + 1) step(1);
		chk(16'(fault_flag_rd), 16'h0001);
		for (n = 0; fault_tx_bit && n < 200; n = n + 1) step(1);
		for (k = 0; !fault_tx_bit && k < 5; k = k + 1) step(1);
		chk(16'(k), 16'h0001);
		for (n = 0; fault_tx_bit && n < 200; n = n + 1) step(1);
		chk(16'(n), 16'h0054);
		signal_detect = 1'b1;
		for (n = 0; fault_tx_active && n < 200; n = n + 1) step(1);
		chk(16'(fault_flag_rd), 16'h0001);
		u_mgmt.access(5'h12, 16'h0000, 1'b1);
		step(1);
		chk(16'(fault_flag_rd), 16'h0000);
		$display("test far fault done");
		conclude;
	end
endmodule // pcfg_control_tb
bind pcfg_control pcfg_control_properties u_props (.*);
